// ### shared/uec_pkg.sv
// Constants for the endpoint control and status block
package uec_pkg;
  // Register map, byte addresses on the 6-bit register port
  localparam logic [5:0] ADR_EP0_CSR = 6'h00;
  localparam logic [5:0] ADR_ENDPOINT0_MAX_PACKET_SIZE = 6'h01;
  localparam logic [5:0] ADR_EP0_CNT = 6'h02;
  // Endpoints 1-4: base 0x10 + 4*(n-1), sub-offsets below
  localparam logic [1:0] ADR_EPX_PAGE = 2'h1;
  localparam logic [1:0] SUB_IN_CSR = 2'h0;
  localparam logic [1:0] SUB_OUT_CSR = 2'h1;
  localparam logic [1:0] SUB_IN_MAX_PACKET_SIZE = 2'h2;
  localparam logic [1:0] SUB_OUT_CNT = 2'h3;
  // Endpoint 0 control/status bit positions
  localparam int B0_RX_WAIT = 0;
  localparam int B0_TX_LOAD = 1;
  localparam int B0_STALL = 2;
  localparam int B0_DATA_END = 3;
  localparam int B0_FSTALL = 4;
  localparam int B0_ABORTED = 5;
  localparam int B0_CLR_RX = 6;
  localparam int B0_CLR_ABT = 7;
  // IN control/status bit positions
  localparam int BI_LOADED = 0;
  localparam int BI_UNDER = 1;
  localparam int BI_STALL = 2;
  localparam int BI_ISO = 3;
  localparam int BI_FEEDBACK = 4;
  localparam int BI_NOT_EMPTY = 5;
  localparam int BI_FLUSH = 6;
  localparam int BI_AUTO_SET = 7;
  // OUT control/status bit positions
  localparam int BO_WAITING = 0;
  localparam int BO_OVER = 1;
  localparam int BO_STALL = 2;
  localparam int BO_ISO = 3;
  localparam int BO_FSTALL = 4;
  localparam int BO_DATA_ERR = 5;
  localparam int BO_FLUSH = 6;
  localparam int BO_RX_READY_AUTO_RELEASE = 7;
  // Reset values and FIFO geometry
  localparam logic [7:0] ENDPOINT0_MAX_PACKET_SIZE_RST = 8'h08;
  localparam logic [7:0] IN_MAX_PACKET_SIZE_RST = 8'h00;
  localparam logic [7:0] FIFO_HALF = 8'h20;
  localparam logic [1:0] PKT_ONE = 2'h1;
  localparam logic [1:0] PKT_TWO = 2'h2;
  // Endpoint 0 control transfer phase
  typedef enum logic [2:0] {
    EP0_IDLE = 3'b001,
    EP0_DATA = 3'b010,
    EP0_STAT = 3'b100
  } uec_ep0_t;
endpackage

// ### rtl/uec_top.sv
// Endpoint control/status registers for endpoints 0 to 4
// Overview of operation
// - Setup-ended sets when transfer ends short or a new setup interrupts it.
// - Writing 1 to EP0 bit 6 clears rx-waiting, bit 7 clears setup-ended.
// - Setup-ended rises at SETUP PID; rx-waiting only after clean packet.
// - EP0 max packet size resets to 8 bytes, shared by IN and OUT.
// - After each good packet, received byte count is loaded for firmware.
// - Writing 1 to tx-loaded queues packet; pointers move on write and send.
// - Iso IN token on empty FIFO sets underrun and shared fault.
// - While send-stall is 1, endpoint answers STALL; writing 0 ends it.
// - IN iso/toggle-init set makes every sent packet DATA0.
// - IN not-empty flag is 1 exactly while a packet sits in the FIFO.
// - Flush empties one packet or drops the older of two.
// - With auto-set, a packet is queued after max-packet bytes are written.
// - Good OUT packet sets waiting; firmware write 0 releases the packet.
// - Iso OUT token with two packets queued sets overrun and shared fault.
// - OUT iso/toggle-init set accepts DATA0 or DATA1.
// - Writing 1 then 0 to iso/toggle-init resets the data toggle to DATA0.
// - Oversize OUT packet sets forced-stall, STALL returned while set.
// - CRC or stuffing error in iso packet sets data-error; write 0 clears.
// - With auto-release, one packet is released after max-packet bytes are read.
// - IN max packet resets to 0; above half FIFO is single buffering.
// - EP0 rx-waiting sets after a valid SETUP or OUT token and its data.
// - Data-end moves EP0 to status phase and clears when status completes.
`timescale 1ns/1ps
module uec_top
  import uec_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST_B,
  input wire logic [5:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic I_EP0_SETUP_PID,
  input wire logic I_EP0_RX_OK,
  input wire logic I_EP0_TX_OK,
  input wire logic I_EP0_STATUS_DONE,
  input wire logic I_EP0_EARLY_END,
  input wire logic I_EP0_PROTO_ERR,
  input wire logic [7:0] I_RX_COUNT,
  input wire logic [3:0] I_IN_TOKEN,
  input wire logic [3:0] I_IN_TX_OK,
  input wire logic [3:0] I_IN_FIFO_WR,
  input wire logic [3:0] I_OUT_TOKEN,
  input wire logic [3:0] I_OUT_RX_OK,
  input wire logic [3:0] I_OUT_OVERSIZE,
  input wire logic [3:0] I_OUT_BAD_CRC,
  input wire logic [3:0] I_OUT_FIFO_RD,
  input wire logic [31:0] I_OUT_MAX_PACKET_SIZE,
  output logic [7:0] O_RDATA,
  output logic O_EP0_STALL,
  output logic O_EP0_STATUS_PHASE,
  output logic [3:0] O_IN_READY,
  output logic [3:0] O_IN_STALL,
  output logic [3:0] O_IN_DATA0_ONLY,
  output logic [3:0] O_IN_FEEDBACK,
  output logic [3:0] O_OUT_ROOM,
  output logic [3:0] O_OUT_STALL,
  output logic [3:0] O_OUT_ANY_PID,
  output logic [3:0] O_TOGGLE_RESET_IN,
  output logic [3:0] O_TOGGLE_RESET_OUT,
  output logic O_FAULT_SET
);

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);

  // Register decode
  logic ep0_csr_wr;
  logic endpoint0_max_packet_size_wr;
  logic epx_sel;
  logic [1:0] epx_idx;
  logic [1:0] epx_sub;
  assign ep0_csr_wr = I_WR && (I_ADDR == ADR_EP0_CSR);
  assign endpoint0_max_packet_size_wr = I_WR && (I_ADDR == ADR_ENDPOINT0_MAX_PACKET_SIZE);
  assign epx_sel = (I_ADDR[5:4] == ADR_EPX_PAGE);
  assign epx_idx = I_ADDR[3:2];
  assign epx_sub = I_ADDR[1:0];

  // Endpoint 0 state
  uec_ep0_t ep0_st_ff;
  uec_ep0_t nxt_ep0_st;
  logic ep0_rx_wait_ff;
  logic ep0_tx_load_ff;
  logic ep0_stall_ff;
  logic ep0_data_end_ff;
  logic ep0_fstall_ff;
  logic ep0_aborted_ff;
  logic [7:0] endpoint0_max_packet_size_ff;
  logic [7:0] ep0_cnt_ff;
  logic ep0_abort_set;
  logic [7:0] ep0_csr;

  // Early end, or a SETUP PID arriving mid-transfer, marks setup-ended
  assign ep0_abort_set = I_EP0_EARLY_END ||
    (I_EP0_SETUP_PID && (ep0_st_ff != EP0_IDLE));

  // Control transfer phase tracking
  always_comb begin
    nxt_ep0_st = ep0_st_ff;
    unique case (ep0_st_ff)
      EP0_IDLE: begin
        if (I_EP0_RX_OK) begin
          nxt_ep0_st = EP0_DATA;
        end
      end
      EP0_DATA: begin
        if (ep0_abort_set) begin
          nxt_ep0_st = EP0_IDLE;
        end else if (ep0_data_end_ff) begin
          nxt_ep0_st = EP0_STAT;
        end
      end
      EP0_STAT: begin
        if (I_EP0_STATUS_DONE || ep0_abort_set) begin
          nxt_ep0_st = EP0_IDLE;
        end
      end
      default: nxt_ep0_st = EP0_IDLE;
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ep0_st_ff <= EP0_IDLE;
    end else begin
      ep0_st_ff <= nxt_ep0_st;
    end
  end

  // Flags that hardware sets: the set wins over a same-cycle clear
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ep0_rx_wait_ff <= 1'b0;
      ep0_aborted_ff <= 1'b0;
      ep0_fstall_ff <= 1'b0;
    end else begin
      if (I_EP0_RX_OK) begin
        ep0_rx_wait_ff <= 1'b1;
      end else if (ep0_csr_wr && I_WDATA[B0_CLR_RX]) begin
        ep0_rx_wait_ff <= 1'b0;
      end
      if (ep0_abort_set) begin
        ep0_aborted_ff <= 1'b1;
      end else if (ep0_csr_wr && I_WDATA[B0_CLR_ABT]) begin
        ep0_aborted_ff <= 1'b0;
      end
      if (I_EP0_PROTO_ERR) begin
        ep0_fstall_ff <= 1'b1;
      end else if (ep0_csr_wr && !I_WDATA[B0_FSTALL]) begin
        ep0_fstall_ff <= 1'b0;
      end
    end
  end

  // Firmware-set EP0 bits and the byte count
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ep0_tx_load_ff <= 1'b0;
      ep0_stall_ff <= 1'b0;
      ep0_data_end_ff <= 1'b0;
      endpoint0_max_packet_size_ff <= ENDPOINT0_MAX_PACKET_SIZE_RST;
      ep0_cnt_ff <= 8'h00;
    end else begin
      if (I_EP0_TX_OK || ep0_abort_set) begin
        ep0_tx_load_ff <= 1'b0;
      end else if (ep0_csr_wr && I_WDATA[B0_TX_LOAD]) begin
        ep0_tx_load_ff <= 1'b1;
      end
      if (ep0_csr_wr) begin
        ep0_stall_ff <= I_WDATA[B0_STALL];
      end
      // Status completion outranks a late firmware set
      if (I_EP0_STATUS_DONE && (ep0_st_ff == EP0_STAT)) begin
        ep0_data_end_ff <= 1'b0;
      end else if (ep0_csr_wr && I_WDATA[B0_DATA_END]) begin
        ep0_data_end_ff <= 1'b1;
      end
      if (endpoint0_max_packet_size_wr) begin
        endpoint0_max_packet_size_ff <= I_WDATA;
      end
      if (I_EP0_RX_OK) begin
        ep0_cnt_ff <= I_RX_COUNT;
      end
    end
  end

  // Clear-request bits always read as zero
  assign ep0_csr = {2'b00, ep0_aborted_ff, ep0_fstall_ff, ep0_data_end_ff,
                    ep0_stall_ff, ep0_tx_load_ff, ep0_rx_wait_ff};

  // Endpoints 1-4, packed views for the read mux and outputs
  logic [31:0] in_csr_v;
  logic [31:0] out_csr_v;
  logic [31:0] in_max_packet_size_v;
  logic [31:0] out_cnt_v;
  logic [3:0] in_ready_v;
  logic [3:0] out_room_v;
  logic [3:0] out_stall_v;
  logic [3:0] tog_in_v;
  logic [3:0] tog_out_v;
  logic [3:0] fault_v;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ep
      logic in_wr;
      logic out_wr;
      logic max_packet_size_wr;
      logic [7:0] in_ctl_ff;
      logic [7:0] out_ctl_ff;
      logic [7:0] max_packet_size_ff;
      logic [7:0] cnt_ff;
      logic [1:0] in_pkts_ff;
      logic [1:0] out_pkts_ff;
      logic [7:0] wr_bytes_ff;
      logic [7:0] rd_bytes_ff;
      logic under_ff;
      logic over_ff;
      logic fstall_ff;
      logic derr_ff;
      logic in_iso_d_ff;
      logic out_iso_d_ff;
      logic [1:0] in_cap;
      logic [1:0] out_cap;
      logic [7:0] out_max_packet_size;
      logic in_iso;
      logic out_iso;
      logic auto_load;
      logic auto_rel;
      logic fw_load;
      logic fw_rel;
      logic in_flush;
      logic out_flush;
      logic under_set;
      logic over_set;

      assign in_wr = I_WR && epx_sel && (epx_idx == gi) &&
                     (epx_sub == SUB_IN_CSR);
      assign out_wr = I_WR && epx_sel && (epx_idx == gi) &&
                      (epx_sub == SUB_OUT_CSR);
      assign max_packet_size_wr = I_WR && epx_sel && (epx_idx == gi) &&
                       (epx_sub == SUB_IN_MAX_PACKET_SIZE);
      assign out_max_packet_size = I_OUT_MAX_PACKET_SIZE[gi*8 +: 8];
      assign in_iso = in_ctl_ff[BI_ISO];
      assign out_iso = out_ctl_ff[BO_ISO];
      // Large packets leave room for only one in the FIFO
      assign in_cap = (max_packet_size_ff > FIFO_HALF) ? PKT_ONE : PKT_TWO;
      assign out_cap = (out_max_packet_size > FIFO_HALF) ? PKT_ONE : PKT_TWO;
      assign auto_load = in_ctl_ff[BI_AUTO_SET] && I_IN_FIFO_WR[gi] &&
        (max_packet_size_ff != 8'h00) && (wr_bytes_ff + 8'h01 == max_packet_size_ff);
      assign auto_rel = out_ctl_ff[BO_RX_READY_AUTO_RELEASE] && I_OUT_FIFO_RD[gi] &&
        (out_max_packet_size != 8'h00) && (rd_bytes_ff + 8'h01 == out_max_packet_size);
      assign fw_load = in_wr && I_WDATA[BI_LOADED];
      assign fw_rel = out_wr && !I_WDATA[BO_WAITING] &&
                      (out_pkts_ff != 2'h0);
      assign in_flush = in_wr && I_WDATA[BI_FLUSH];
      assign out_flush = out_wr && I_WDATA[BO_FLUSH];
      assign under_set = in_iso && I_IN_TOKEN[gi] &&
                         (in_pkts_ff == 2'h0);
      assign over_set = out_iso && I_OUT_TOKEN[gi] &&
                        (out_pkts_ff == PKT_TWO);

      // Firmware control bits; bit 0 of each CSR is held elsewhere
      always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
          in_ctl_ff <= 8'h00;
          out_ctl_ff <= 8'h00;
          max_packet_size_ff <= IN_MAX_PACKET_SIZE_RST;
        end else begin
          if (in_wr) begin
            in_ctl_ff <= I_WDATA & 8'h9c;
          end
          if (out_wr) begin
            out_ctl_ff <= I_WDATA & 8'h8c;
          end
          if (max_packet_size_wr) begin
            max_packet_size_ff <= I_WDATA;
          end
        end
      end

      // Packet occupancy of the IN FIFO; one update per cycle at most
      always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
          in_pkts_ff <= 2'h0;
          wr_bytes_ff <= 8'h00;
        end else begin
          if ((fw_load || auto_load) && (in_pkts_ff < in_cap)) begin
            in_pkts_ff <= in_pkts_ff + 2'h1;
          end else if ((I_IN_TX_OK[gi] || in_flush) &&
                       (in_pkts_ff != 2'h0)) begin
            in_pkts_ff <= in_pkts_ff - 2'h1;
          end
          if (auto_load || fw_load || in_flush) begin
            wr_bytes_ff <= 8'h00;
          end else if (I_IN_FIFO_WR[gi]) begin
            wr_bytes_ff <= wr_bytes_ff + 8'h01;
          end
        end
      end

      // Packet occupancy of the OUT FIFO and the byte count
      always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
          out_pkts_ff <= 2'h0;
          rd_bytes_ff <= 8'h00;
          cnt_ff <= 8'h00;
        end else begin
          if (I_OUT_RX_OK[gi] && (out_pkts_ff < out_cap)) begin
            out_pkts_ff <= out_pkts_ff + 2'h1;
            cnt_ff <= I_RX_COUNT;
          end else if ((fw_rel || auto_rel || out_flush) &&
                       (out_pkts_ff != 2'h0)) begin
            out_pkts_ff <= out_pkts_ff - 2'h1;
          end
          if (auto_rel || fw_rel || out_flush) begin
            rd_bytes_ff <= 8'h00;
          end else if (I_OUT_FIFO_RD[gi]) begin
            rd_bytes_ff <= rd_bytes_ff + 8'h01;
          end
        end
      end

      // Error flags, cleared by writing 0; a new event wins the cycle
      always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
          under_ff <= 1'b0;
          over_ff <= 1'b0;
          fstall_ff <= 1'b0;
          derr_ff <= 1'b0;
        end else begin
          if (under_set) begin
            under_ff <= 1'b1;
          end else if (in_wr && !I_WDATA[BI_UNDER]) begin
            under_ff <= 1'b0;
          end
          if (over_set) begin
            over_ff <= 1'b1;
          end else if (out_wr && !I_WDATA[BO_OVER]) begin
            over_ff <= 1'b0;
          end
          if (I_OUT_OVERSIZE[gi]) begin
            fstall_ff <= 1'b1;
          end else if (out_wr && !I_WDATA[BO_FSTALL]) begin
            fstall_ff <= 1'b0;
          end
          if (out_iso && I_OUT_BAD_CRC[gi]) begin
            derr_ff <= 1'b1;
          end else if (out_wr && !I_WDATA[BO_DATA_ERR]) begin
            derr_ff <= 1'b0;
          end
        end
      end

      // Delayed iso bits catch the 1-then-0 toggle reset sequence
      always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
          in_iso_d_ff <= 1'b0;
          out_iso_d_ff <= 1'b0;
        end else begin
          in_iso_d_ff <= in_iso;
          out_iso_d_ff <= out_iso;
        end
      end

      assign tog_in_v[gi] = in_iso_d_ff && !in_iso;
      assign tog_out_v[gi] = out_iso_d_ff && !out_iso;
      assign fault_v[gi] = under_set || over_set;
      // Ready to send means a whole packet is queued
      assign in_ready_v[gi] = (in_pkts_ff != 2'h0);
      assign out_room_v[gi] = (out_pkts_ff < out_cap);
      assign out_stall_v[gi] = out_ctl_ff[BO_STALL] || fstall_ff;
      assign in_csr_v[gi*8 +: 8] = {in_ctl_ff[BI_AUTO_SET], 1'b0,
        (in_pkts_ff != 2'h0), in_ctl_ff[BI_FEEDBACK], in_ctl_ff[BI_ISO],
        in_ctl_ff[BI_STALL], under_ff, (in_pkts_ff == in_cap)};
      assign out_csr_v[gi*8 +: 8] = {out_ctl_ff[BO_RX_READY_AUTO_RELEASE], 1'b0,
        derr_ff, fstall_ff, out_ctl_ff[BO_ISO], out_ctl_ff[BO_STALL],
        over_ff, (out_pkts_ff != 2'h0)};
      assign in_max_packet_size_v[gi*8 +: 8] = max_packet_size_ff;
      assign out_cnt_v[gi*8 +: 8] = cnt_ff;
    end
  endgenerate

  // Read data one cycle after the strobe, zero otherwise or unmapped
  logic [7:0] nxt_rdata;
  always_comb begin
    nxt_rdata = 8'h00;
    if (I_RD) begin
      if (I_ADDR == ADR_EP0_CSR) begin
        nxt_rdata = ep0_csr;
      end else if (I_ADDR == ADR_ENDPOINT0_MAX_PACKET_SIZE) begin
        nxt_rdata = endpoint0_max_packet_size_ff;
      end else if (I_ADDR == ADR_EP0_CNT) begin
        nxt_rdata = ep0_cnt_ff;
      end else if (epx_sel) begin
        unique case (epx_sub)
          SUB_IN_CSR: nxt_rdata = in_csr_v[epx_idx*8 +: 8];
          SUB_OUT_CSR: nxt_rdata = out_csr_v[epx_idx*8 +: 8];
          SUB_IN_MAX_PACKET_SIZE: nxt_rdata = in_max_packet_size_v[epx_idx*8 +: 8];
          SUB_OUT_CNT: nxt_rdata = out_cnt_v[epx_idx*8 +: 8];
        endcase
      end
    end
  end

  // Registered outputs toward the serial engine and the CPU
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_RDATA <= 8'h00;
      O_EP0_STALL <= 1'b0;
      O_EP0_STATUS_PHASE <= 1'b0;
      O_IN_READY <= 4'h0;
      O_IN_STALL <= 4'h0;
      O_IN_DATA0_ONLY <= 4'h0;
      O_IN_FEEDBACK <= 4'h0;
      O_OUT_ROOM <= 4'h0;
      O_OUT_STALL <= 4'h0;
      O_OUT_ANY_PID <= 4'h0;
      O_TOGGLE_RESET_IN <= 4'h0;
      O_TOGGLE_RESET_OUT <= 4'h0;
      O_FAULT_SET <= 1'b0;
    end else begin
      O_RDATA <= nxt_rdata;
      O_EP0_STALL <= ep0_stall_ff || ep0_fstall_ff;
      O_EP0_STATUS_PHASE <= (ep0_st_ff == EP0_STAT);
      O_IN_READY <= in_ready_v;
      for (int k = 0; k < 4; k++) begin
        O_IN_STALL[k] <= in_csr_v[k*8 + BI_STALL];
        O_IN_DATA0_ONLY[k] <= in_csr_v[k*8 + BI_ISO];
        O_IN_FEEDBACK[k] <= in_csr_v[k*8 + BI_FEEDBACK];
        O_OUT_ANY_PID[k] <= out_csr_v[k*8 + BO_ISO];
      end
      O_OUT_ROOM <= out_room_v;
      O_OUT_STALL <= out_stall_v;
      O_TOGGLE_RESET_IN <= tog_in_v;
      O_TOGGLE_RESET_OUT <= tog_out_v;
      O_FAULT_SET <= |fault_v;
    end
  end

  // Checks next to the logic they guard
  a_setup_pid_abort: assert property (
    I_EP0_SETUP_PID && ep0_st_ff == EP0_DATA |=> ep0_aborted_ff)
    else $error("setup-ended not raised at SETUP PID");
  a_rx_wait_set: assert property (
    I_EP0_RX_OK |=> ep0_rx_wait_ff && ep0_cnt_ff == $past(I_RX_COUNT))
    else $error("EP0 packet not flagged or counted");
  a_clear_needs_one: assert property (
    ep0_rx_wait_ff && !I_EP0_RX_OK && !(ep0_csr_wr && I_WDATA[B0_CLR_RX])
    |=> ep0_rx_wait_ff)
    else $error("rx-waiting lost without a clear request");
  a_clear_bits_zero: assert property (
    I_RD && I_ADDR == ADR_EP0_CSR |=> O_RDATA[7:6] == 2'b00)
    else $error("EP0 clear bits read nonzero");
  a_max_packet_size_reset: assert property (
    $rose(I_RST_B) |-> endpoint0_max_packet_size_ff == 8'h08)
    else $error("EP0 max packet not 8 after reset");
  a_status_leaves: assert property (
    ep0_st_ff == EP0_STAT && I_EP0_STATUS_DONE |=>
    ep0_st_ff == EP0_IDLE ##1 !O_EP0_STATUS_PHASE)
    else $error("status phase not ended");
  a_underrun_flag: assert property (
    I_IN_TOKEN[0] && in_csr_v[BI_ISO] && !in_ready_v[0] |=>
    in_csr_v[BI_UNDER] && O_FAULT_SET)
    else $error("underrun or shared fault missing");
  a_stall_follows: assert property (
    out_csr_v[8 + BO_STALL] [*2] |-> O_OUT_STALL[1])
    else $error("OUT stall not driven");
  a_not_empty_match: assert property (
    I_WR && I_ADDR == {ADR_EPX_PAGE, 2'h0, SUB_IN_CSR} &&
    I_WDATA[BI_LOADED] |=> in_csr_v[BI_NOT_EMPTY] ##1 O_IN_READY[0])
    else $error("IN not-empty disagrees with occupancy");
  a_toggle_pulse: assert property (
    out_csr_v[8 + BO_ISO] ##1 !out_csr_v[8 + BO_ISO] |=>
    O_TOGGLE_RESET_OUT[1])
    else $error("toggle reset not pulsed");
  a_oversize_stall: assert property (
    I_OUT_OVERSIZE[1] |=> out_csr_v[8 + BO_FSTALL] ##1 O_OUT_STALL[1])
    else $error("forced stall not set on oversize");

endmodule

// ### dv/uec_host_model.sv
// Host and serial engine model that issues link event pulses
`timescale 1ns/1ps
module uec_host_model (
  input wire logic i_clk,
  output logic [5:0] o_ep0,
  output logic [7:0] o_count,
  output logic [7:0][3:0] o_ev
);
  // Idle until the bench asks for an event
  initial begin
    o_ep0 = '0;
    o_count = 8'h5a;
    o_ev = '0;
  end

  // One pulse; k<6 is an endpoint 0 event, else per-endpoint mask m
  task automatic fire(input int k, input logic [3:0] m,
                      input logic [7:0] c);
    @(posedge i_clk);
    o_ep0 <= (k < 6) ? 6'(1 << k) : 6'h00;
    o_ev <= (k < 6) ? 32'h0 : 32'(m) << (4 * (k - 6));
    o_count <= c;
    @(posedge i_clk);
    o_ep0 <= '0;
    o_ev <= '0;
    // Count is only valid with its pulse, so scramble it after
    o_count <= ~c;
  endtask
endmodule

// ### dv/uec_top_bench.sv
// Self-checking bench for the endpoint control and status block
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
  errors++; $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module uec_top_bench;
  import uec_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [5:0] addr = '0;
  logic [7:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] out_max_packet_size = 32'h0000_0400;
  logic [5:0] ep0;
  logic [7:0] cnt;
  logic [7:0][3:0] ev;
  logic [7:0] rdata;
  logic ep0_stall, st_ph, fault, fault_seen, tog_seen;
  logic [3:0] in_rdy, in_stall, in_d0, in_fb, out_stall, out_any, tog_in;
  logic [3:0] out_room, tog_out;
  int errors = 0;
  int comparisons = 0;

  // 250 MHz clock
  always #2 clk = ~clk;

  // Catch one-cycle pulses so their exact cycle need not be guessed
  always @(posedge clk) begin
    if (fault) fault_seen <= 1'b1;
    if (tog_in[0] || tog_out[1]) tog_seen <= 1'b1;
  end

  uec_host_model uec_host_model_i (.i_clk(clk), .o_ep0(ep0),
    .o_count(cnt), .o_ev(ev));

  uec_top uec_top_i (.I_CLK(clk), .I_RST_B(rst_b), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .I_EP0_SETUP_PID(ep0[0]),
    .I_EP0_RX_OK(ep0[1]), .I_EP0_TX_OK(ep0[2]),
    .I_EP0_STATUS_DONE(ep0[3]), .I_EP0_EARLY_END(ep0[4]),
    .I_EP0_PROTO_ERR(ep0[5]), .I_RX_COUNT(cnt), .I_IN_TOKEN(ev[0]),
    .I_IN_TX_OK(ev[1]), .I_IN_FIFO_WR(ev[2]), .I_OUT_TOKEN(ev[3]),
    .I_OUT_RX_OK(ev[4]), .I_OUT_OVERSIZE(ev[5]), .I_OUT_BAD_CRC(ev[6]),
    .I_OUT_FIFO_RD(ev[7]), .I_OUT_MAX_PACKET_SIZE(out_max_packet_size), .O_RDATA(rdata),
    .O_EP0_STALL(ep0_stall), .O_EP0_STATUS_PHASE(st_ph),
    .O_IN_READY(in_rdy), .O_IN_STALL(in_stall), .O_IN_DATA0_ONLY(in_d0),
    .O_IN_FEEDBACK(in_fb), .O_OUT_ROOM(out_room), .O_OUT_STALL(out_stall),
    .O_OUT_ANY_PID(out_any), .O_TOGGLE_RESET_IN(tog_in),
    .O_TOGGLE_RESET_OUT(tog_out), .O_FAULT_SET(fault));

  // Bus write, one strobe cycle
  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Bus read, data looked at only in the cycle after the strobe
  task automatic chk_reg(input logic [5:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask

  // Event, then the two edges until outputs follow
  task automatic host(input int k, input logic [3:0] m,
                      input logic [7:0] c);
    uec_host_model_i.fire(k, m, c);
    repeat (2) @(posedge clk);
    #1;
  endtask

  // Reset values, RW, RO and unmapped places
  task automatic test_reset();
    chk_reg(ADR_ENDPOINT0_MAX_PACKET_SIZE, 8'h08);
    chk_reg(6'h12, 8'h00);
    chk_reg(ADR_EP0_CSR, 8'h00);
    chk_reg(6'h3f, 8'h00);
    wr_reg(ADR_EP0_CNT, 8'hff);
    chk_reg(ADR_EP0_CNT, 8'h00);
    wr_reg(ADR_ENDPOINT0_MAX_PACKET_SIZE, 8'h40);
    chk_reg(ADR_ENDPOINT0_MAX_PACKET_SIZE, 8'h40);
  endtask

  // Endpoint 0 control transfer, clear bits and an early setup
  task automatic test_ep0();
    host(1, 4'h0, 8'h05);
    chk_reg(ADR_EP0_CSR, 8'h01);
    chk_reg(ADR_EP0_CNT, 8'h05);
    wr_reg(ADR_EP0_CSR, 8'h00);
    chk_reg(ADR_EP0_CSR, 8'h01);
    wr_reg(ADR_EP0_CSR, 8'h48);
    chk_reg(ADR_EP0_CSR, 8'h08);
    `CHK(st_ph, 1'b1)
    host(3, 4'h0, 8'h00);
    chk_reg(ADR_EP0_CSR, 8'h00);
    `CHK(st_ph, 1'b0)
    host(1, 4'h0, 8'h03);
    wr_reg(ADR_EP0_CSR, 8'h40);
    host(0, 4'h0, 8'h00);
    chk_reg(ADR_EP0_CSR, 8'h20);
    host(1, 4'h0, 8'h08);
    chk_reg(ADR_EP0_CSR, 8'h21);
    // Firmware drops the old request before any FIFO access
    wr_reg(ADR_EP0_CSR, 8'hc0);
    chk_reg(ADR_EP0_CSR, 8'h00);
    host(4, 4'h0, 8'h00);
    chk_reg(ADR_EP0_CSR, 8'h20);
    wr_reg(ADR_EP0_CSR, 8'h84);
    chk_reg(ADR_EP0_CSR, 8'h04);
    `CHK(ep0_stall, 1'b1)
    wr_reg(ADR_EP0_CSR, 8'h02);
    chk_reg(ADR_EP0_CSR, 8'h02);
    host(2, 4'h0, 8'h00);
    chk_reg(ADR_EP0_CSR, 8'h00);
    host(5, 4'h0, 8'h00);
    chk_reg(ADR_EP0_CSR, 8'h10);
    `CHK(ep0_stall, 1'b1)
  endtask

  // IN endpoint 1: buffering, flush, auto-set, iso, underrun
  task automatic test_in();
    wr_reg(6'h12, 8'h40);
    wr_reg(6'h10, 8'h01);
    chk_reg(6'h10, 8'h21);
    `CHK(in_rdy[0], 1'b1)
    wr_reg(6'h10, 8'h40);
    chk_reg(6'h10, 8'h00);
    wr_reg(6'h12, 8'h10);
    wr_reg(6'h10, 8'h01);
    chk_reg(6'h10, 8'h20);
    wr_reg(6'h10, 8'h01);
    chk_reg(6'h10, 8'h21);
    wr_reg(6'h10, 8'h40);
    chk_reg(6'h10, 8'h20);
    host(7, 4'h1, 8'h00);
    chk_reg(6'h10, 8'h00);
    wr_reg(6'h10, 8'h80);
    repeat (15) uec_host_model_i.fire(8, 4'h1, 8'h00);
    chk_reg(6'h10, 8'h80);
    host(8, 4'h1, 8'h00);
    chk_reg(6'h10, 8'ha0);
    wr_reg(6'h10, 8'h40);
    // Feedback set only because this endpoint carries rate data
    wr_reg(6'h10, 8'h1c);
    fault_seen = 1'b0;
    tog_seen = 1'b0;
    host(6, 4'h1, 8'h00);
    chk_reg(6'h10, 8'h1e);
    `CHK(fault_seen, 1'b1)
    `CHK({in_stall[0], in_d0[0], in_fb[0]}, 3'b111)
    wr_reg(6'h10, 8'h00);
    chk_reg(6'h10, 8'h00);
    `CHK({in_stall[0], tog_seen}, 2'b01)
  endtask

  // OUT endpoint 2: count, release, forced stall, iso faults, auto-clear
  task automatic test_out();
    host(10, 4'h2, 8'h07);
    chk_reg(6'h15, 8'h01);
    chk_reg(6'h17, 8'h07);
    wr_reg(6'h15, 8'h32);
    chk_reg(6'h15, 8'h00);
    host(11, 4'h2, 8'h00);
    chk_reg(6'h15, 8'h10);
    `CHK(out_stall[1], 1'b1)
    wr_reg(6'h15, 8'h00);
    chk_reg(6'h15, 8'h00);
    `CHK(out_stall[1], 1'b0)
    wr_reg(6'h15, 8'h08);
    host(12, 4'h2, 8'h00);
    chk_reg(6'h15, 8'h28);
    `CHK(out_any[1], 1'b1)
    fault_seen = 1'b0;
    host(10, 4'h2, 8'h04);
    host(10, 4'h2, 8'h04);
    host(9, 4'h2, 8'h00);
    chk_reg(6'h15, 8'h2b);
    `CHK(fault_seen, 1'b1)
    `CHK(out_room[1], 1'b0)
    wr_reg(6'h15, 8'hae);
    chk_reg(6'h15, 8'haf);
    repeat (3) uec_host_model_i.fire(13, 4'h2, 8'h00);
    chk_reg(6'h15, 8'haf);
    host(13, 4'h2, 8'h00);
    chk_reg(6'h15, 8'hae);
    tog_seen = 1'b0;
    wr_reg(6'h15, 8'h00);
    chk_reg(6'h15, 8'h00);
    `CHK({tog_seen, out_room[1]}, 2'b11)
  endtask

  // Verdict and end of run
  task automatic stop_test();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #40000;
    errors++;
    stop_test();
  end

  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    test_reset();
    test_ep0();
    test_in();
    test_out();
    stop_test();
  end
endmodule
